// [common/crc_snoop_defines.svh]
`ifndef CRC_SNOOP_DEFINES_SVH
`define CRC_SNOOP_DEFINES_SVH

// register byte offsets on the wishbone slave
`define OFS_INPUT 8'h00
`define OFS_RESULT 8'h04
`define OFS_SNOOP 8'h08
`define OFS_CTRL 8'h0C
`define OFS_STATUS 8'h10

// snoop target register fields
`define SNOOP_WR_BIT 15
`define SNOOP_RD_BIT 14
`define SNOOP_ADDR_W 14

// control and status fields
`define CTRL_POLY_BIT 0
`define STATUS_BUSY_BIT 0

// generator polynomials, reflected for lsb-first processing
`define POLY_CCITT_REFL 16'h8408
`define POLY_CRC16_REFL 16'hA001

// reset values
`define RESULT_RST 16'h0000
`define SNOOP_RST 16'h0000
`define CTRL_RST 1'b0

// one byte is captured in one cycle and folded in the next, so it just meets the two-cycle limit
`define FOLD_CYCLES 1

`endif

// [common/crc_snoop_pkg.sv]
package crc_snoop_pkg;

    // observed access on the peripheral bus
    typedef struct packed {
        logic valid;
        logic we;
        logic [13:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic word;
    } snoop_bus_s;

    typedef enum logic [1:0] {
        POLY_CCITT = 2'b01,
        POLY_CRC16 = 2'b10
    } poly_sel_e;

endpackage

// [rtl/crc_snoop_engine.sv]
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
`include "crc_snoop_defines.svh"
// Functional notes
// - code uses ccitt or crc-16 generator polynomial, both degree 16
// - a 16-bit check code covers any whole number of bytes
// - each byte written to the input register is folded into the result
// - one byte's code update completes within two machine cycles
// - snoop target register holds the watched peripheral address
// - top two bits of snoop target enable write and read snooping
// - snooped writes to the target are captured and folded; code drops one that meets a software input-byte write in the same cycle
// - snooped reads of the target are captured and folded; code drops one that meets a software input-byte write in the same cycle
// - in word cycles only the watched byte is captured
module crc_snoop_engine (
    input wire logic clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire crc_snoop_pkg::snoop_bus_s snoop_i
);
    import crc_snoop_pkg::*;

    logic [7:0] check_input_byte_reg_ff;
    logic [15:0] check_result_reg_ff;
    logic [15:0] snoop_target_addr_reg_ff;
    logic poly_ctrl_ff;
    logic fold_pending_ff;
    logic [31:0] nxt_dat;
    logic [15:0] nxt_crc;
    logic bus_req;
    logic bus_wr;
    logic sw_byte_wr;
    logic snoop_hit;
    logic [7:0] snoop_byte;
    logic [15:0] poly_value;
    logic snoop_write_enable;
    logic snoop_read_enable;

    ////////////////////////////////////////////////////////////////////////
    // wishbone decode: single-cycle ack, dropped after one cycle
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr = bus_req & wb_we_i;
    assign sw_byte_wr = bus_wr & (wb_adr_i == `OFS_INPUT) & wb_sel_i[0];

    assign snoop_write_enable = snoop_target_addr_reg_ff[`SNOOP_WR_BIT];
    assign snoop_read_enable = snoop_target_addr_reg_ff[`SNOOP_RD_BIT];

    // full-field compare on the word-aligned address; lane from bit 0
    always_comb begin
        snoop_hit = 1'b0;
        snoop_byte = 8'h00;
        if (snoop_i.valid &&
            snoop_i.addr[13:1] == snoop_target_addr_reg_ff[13:1] &&
            (snoop_i.word || snoop_i.addr[0] == snoop_target_addr_reg_ff[0])) begin
            if (snoop_i.we && snoop_write_enable) begin
                snoop_hit = 1'b1;
                snoop_byte = snoop_target_addr_reg_ff[0] ? snoop_i.wdata[15:8]
                                                         : snoop_i.wdata[7:0];
            end else if (!snoop_i.we && snoop_read_enable) begin
                snoop_hit = 1'b1;
                snoop_byte = snoop_target_addr_reg_ff[0] ? snoop_i.rdata[15:8]
                                                         : snoop_i.rdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // crc datapath: bit-serial division unrolled over the held byte
    assign poly_value = poly_ctrl_ff ? `POLY_CRC16_REFL : `POLY_CCITT_REFL;

    always_comb begin
        nxt_crc = check_result_reg_ff;
        for (int i = 0; i < 8; i++) begin
            // lsb first, so the reflected polynomial shifts right
            if (nxt_crc[0] ^ check_input_byte_reg_ff[i]) begin
                nxt_crc = (nxt_crc >> 1) ^ poly_value;
            end else begin
                nxt_crc = nxt_crc >> 1;
            end
        end
    end

    // byte capture; software write wins over a snoop in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            check_input_byte_reg_ff <= 8'h00;
            fold_pending_ff <= 1'b0;
        end else begin
            fold_pending_ff <= sw_byte_wr | snoop_hit;
            if (sw_byte_wr) begin
                check_input_byte_reg_ff <= wb_dat_i[7:0];
            end else if (snoop_hit) begin
                check_input_byte_reg_ff <= snoop_byte;
            end
        end
    end

    // result: folded the cycle after capture, so done in two cycles
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            check_result_reg_ff <= `RESULT_RST;
        end else if (bus_wr && wb_adr_i == `OFS_RESULT) begin
            // seed load; a pending fold is overridden by the new seed
            if (wb_sel_i[0]) begin
                check_result_reg_ff[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                check_result_reg_ff[15:8] <= wb_dat_i[15:8];
            end
        end else if (fold_pending_ff) begin
            check_result_reg_ff <= nxt_crc;
        end
    end

    // snoop target and polynomial control
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            snoop_target_addr_reg_ff <= `SNOOP_RST;
            poly_ctrl_ff <= `CTRL_RST;
        end else begin
            if (bus_wr && wb_adr_i == `OFS_SNOOP) begin
                if (wb_sel_i[0]) begin
                    snoop_target_addr_reg_ff[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    snoop_target_addr_reg_ff[15:8] <= wb_dat_i[15:8];
                end
            end
            if (bus_wr && wb_adr_i == `OFS_CTRL && wb_sel_i[0]) begin
                poly_ctrl_ff <= wb_dat_i[`CTRL_POLY_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; unmapped offsets read zero and are still acked
    always_comb begin
        nxt_dat = 32'h0000_0000;
        if (wb_adr_i == `OFS_INPUT) begin
            nxt_dat[7:0] = check_input_byte_reg_ff;
        end else if (wb_adr_i == `OFS_RESULT) begin
            nxt_dat[15:0] = check_result_reg_ff;
        end else if (wb_adr_i == `OFS_SNOOP) begin
            nxt_dat[15:0] = snoop_target_addr_reg_ff;
        end else if (wb_adr_i == `OFS_CTRL) begin
            nxt_dat[`CTRL_POLY_BIT] = poly_ctrl_ff;
        end else if (wb_adr_i == `OFS_STATUS) begin
            nxt_dat[`STATUS_BUSY_BIT] = fold_pending_ff;
        end
    end

    // ack one cycle after the strobe; data registered with it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= nxt_dat;
            end
        end
    end

endmodule

// [tb/crc_sva.sv]
`timescale 1ns/10ps
`include "crc_snoop_defines.svh"
module crc_sva (
    input wire logic clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // a read answer is an ack with the request still held as a read
    wire rd = wb_ack_o && !wb_we_i;
    ////////////////////////////////////////
    ack_in_one_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("stray ack");
    data_hold_a: assert property (!rd |-> $stable(wb_dat_o)) else $error("data moved");
    upper_zero_a: assert property (rd |-> wb_dat_o[31:16] == 16'h0)
        else $error("upper half set");
    input_byte_a: assert property (rd && wb_adr_i == `OFS_INPUT |-> wb_dat_o[15:8] == 8'h0)
        else $error("input wider");
    ctrl_bits_a: assert property (rd && wb_adr_i == `OFS_CTRL |-> wb_dat_o[15:1] == 15'h0)
        else $error("ctrl bits set");
    unmapped_a: assert property (rd && wb_adr_i == 8'h14 |-> wb_dat_o == 32'h0)
        else $error("unmapped data");
    cover property (rd && wb_adr_i == `OFS_RESULT);
    cover property (wb_ack_o && wb_we_i && wb_adr_i == `OFS_SNOOP);
    cover property (rd && wb_adr_i == 8'h14);
endmodule

// [tb/cpu_bus.sv]
`timescale 1ns/10ps
module cpu_bus (
    input wire logic clk,
    output crc_snoop_pkg::snoop_bus_s bus
);
    import crc_snoop_pkg::*;
    initial bus = '0;
    // one observed access per call; released data turns to junk so stale bytes never match
    task automatic access(input logic w, input logic [13:0] a, input logic [15:0] d, input logic wd);
        @(posedge clk);
        bus <= '{1'b1, w, a, w ? d : ~d, w ? ~d : d, wd};
        @(posedge clk);
        bus.valid <= 1'b0;
        bus.wdata <= ~bus.wdata;
        bus.rdata <= ~bus.rdata;
    endtask
endmodule

// [tb/tb_top.sv]
`timescale 1ns/10ps
`include "crc_snoop_defines.svh"
module tb_top;
    import crc_snoop_pkg::*;
    logic clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, ack, pol;
    logic [7:0] adr = 0;
    logic [3:0] sel = 0;
    logic [31:0] wd = 0, rd, dat;
    logic [15:0] crc, rv;
    int mismatches = 0, checks = 0;
    snoop_bus_s sb;
    always #5 clk = ~clk;
    crc_snoop_engine crc_snoop_engine_inst (.clk(clk), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
        .wb_dat_o(dat), .wb_ack_o(ack), .snoop_i(sb));
    cpu_bus cpu_bus_inst (.clk(clk), .bus(sb));
    ////////////////////////////////////////
    // lsb-first division, one bit per step
    function automatic logic [15:0] fold(logic [15:0] c, logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            c = (c >> 1) ^ (c[0] ^ b[i] ? (pol ? `POLY_CRC16_REFL : `POLY_CCITT_REFL) : 16'h0);
        end
        return c;
    endfunction
    // classic cycle, held until ack; only the watchdog may end a hung wait
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, sel, wd} <= {2'b11, w, a, 4'h3, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        rd = dat;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        bus(1'b0, a, 32'h0);
        checks++;
        if (rd[15:0] !== exp) begin
            mismatches++;
            $display("unexpected at %0t: addr %h got %h want %h", $time, a, rd[15:0], exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // watchdog: the sequence needs well under 1000 cycles
    initial begin
        #20000;
        mismatches++;
        conclude();
    end
    ////////////////////////////////////////
    initial begin
        void'($urandom(32'h36182159));
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rdchk(`OFS_RESULT, `RESULT_RST);
        rdchk(`OFS_SNOOP, `SNOOP_RST);
        rdchk(8'h14, 16'h0);
        rdchk(`OFS_STATUS, 16'h0);
        for (int p = 0; p < 2; p++) begin
            pol = p[0];
            bus(1'b1, `OFS_CTRL, {31'h0, pol});
            rdchk(`OFS_CTRL, {15'h0, pol});
            crc = 16'($urandom);
            bus(1'b1, `OFS_RESULT, {16'h0, crc});
            repeat (3) begin
                rv = 16'($urandom);
                bus(1'b1, `OFS_INPUT, {24'h0, rv[7:0]});
                crc = fold(crc, rv[7:0]);
            end
            rdchk(`OFS_RESULT, crc);
            rdchk(`OFS_INPUT, {8'h0, rv[7:0]});
            $display("poly test %0d done", p);
        end
        // write snoop only: a read and a neighbour address must leave the code alone
        bus(1'b1, `OFS_SNOOP, 32'h8122);
        cpu_bus_inst.access(1'b1, 14'h0122, 16'h5A5A, 1'b0);
        crc = fold(crc, 8'h5A);
        cpu_bus_inst.access(1'b0, 14'h0122, 16'h3C3C, 1'b0);
        cpu_bus_inst.access(1'b1, 14'h0124, 16'h7777, 1'b0);
        repeat (2) @(posedge clk);
        rdchk(`OFS_RESULT, crc);
        // read snoop of an odd byte inside word cycles
        bus(1'b1, `OFS_SNOOP, 32'h4123);
        cpu_bus_inst.access(1'b0, 14'h0122, 16'hA55A, 1'b1);
        crc = fold(crc, 8'hA5);
        cpu_bus_inst.access(1'b1, 14'h0122, 16'h1111, 1'b1);
        repeat (2) @(posedge clk);
        rdchk(`OFS_RESULT, crc);
        $display("snoop test done");
        conclude();
    end
endmodule
bind crc_snoop_engine crc_sva crc_sva_inst (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));
